// file: src/wsg_pkg.sv
/*
 * Shared constants and types of the word swap, scatter and gather datapath.
 * Assumes nothing of its surroundings; it is compiled before every other file.
 */
package wsg_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int unsigned DATA_W = 16;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned OP_W   = 12;

    // ------------------------------------------------------------------
    // Function codes, held as three BCD digits
    // ------------------------------------------------------------------
    localparam logic [OP_W-1:0] OP_SWAP_WORDS = 12'h073;
    localparam logic [OP_W-1:0] OP_SCATTER    = 12'h080;
    localparam logic [OP_W-1:0] OP_GATHER     = 12'h081;

    // ------------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------------
    localparam logic [DATA_W-1:0] WORD_ZERO    = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_RST     = 16'h0000;
    localparam logic [OP_W-1:0]   OP_RST       = 12'h000;
    localparam logic              FLAG_RST     = 1'b0;
    localparam int unsigned       SIGN_BIT_POS = DATA_W - 1;

    // ------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_RDA   = 3'b001,
        ST_RDB   = 3'b010,
        ST_WAITB = 3'b011,
        ST_WRA   = 3'b100,
        ST_WRB   = 3'b101,
        ST_WAIT  = 3'b110,
        ST_WR    = 3'b111
    } wsg_state_t;

endpackage

// file: src/wsg_word_if.sv
/*
 * Carrier between the sequencer and the word condition evaluator.
 * Assumes both ends sit in the same clock domain; the evaluation is combinational.
 */
`timescale 1ns/100ps

interface wsg_word_if;
    logic [wsg_pkg::DATA_W-1:0] word;
    logic                       zero;
    logic                       sign;

    // The evaluator looks at a word and reports its conditions.
    modport eval (input word, output zero, output sign);
    // The sequencer offers a word and reads the conditions back.
    modport user (output word, input zero, input sign);
endinterface

// file: src/wsg_word_flags.sv
/*
 * Condition evaluator for the moved word: zero and sign.
 * Assumes the word is stable in the cycle in which the sequencer samples the result.
 */
`timescale 1ns/100ps

module wsg_word_flags (
    wsg_word_if.eval flg
);

    // zero detection
    // Zero condition holds only for an all-zero word.
    assign flg.zero = (flg.word == wsg_pkg::WORD_ZERO);

    // sign detection
    // Sign condition follows the most significant bit.
    assign flg.sign = flg.word[wsg_pkg::SIGN_BIT_POS];

endmodule

// file: src/wsg_top.sv
/*
 * Execution datapath for the swap, scatter and gather word operations.
 * Assumes a word data area with a registered read port: read data appears in the cycle
 * after mem_rd_o, and a write takes effect at the edge that ends a mem_wr_o cycle.
 * Operands and the function code come from same-clock execution logic.
 */
`timescale 1ns/100ps

// Behaviour
// - Swap, code 073, exchanges the full contents of its two operand words.
// - Scatter, code 080, writes the source word to base plus displacement.
// - Gather, code 081, reads base plus displacement into the destination word.
// - Displacement is unsigned 16-bit, any value from 0000 through FFFF accepted.
// - Indexed operations set zero flag when moved word is zero, else clear.
// - Indexed operations set sign flag from the moved word's top bit.
module wsg_top (
    input  wire logic                         mclk_i,
    input  wire logic                         nrst_i,
    input  wire logic                         ce_i,
    input  wire logic                         start_i,
    input  wire logic [wsg_pkg::OP_W-1:0]     op_code_i,
    input  wire logic [wsg_pkg::ADDR_W-1:0]   first_swap_word_i,
    input  wire logic [wsg_pkg::ADDR_W-1:0]   second_swap_word_i,
    input  wire logic [wsg_pkg::ADDR_W-1:0]   base_word_address_i,
    input  wire logic [wsg_pkg::DATA_W-1:0]   index_displacement_i,
    input  wire logic [wsg_pkg::DATA_W-1:0]   mem_rdata_i,
    output logic      [wsg_pkg::ADDR_W-1:0]   mem_addr_o,
    output logic                              mem_rd_o,
    output logic                              mem_wr_o,
    output logic      [wsg_pkg::DATA_W-1:0]   mem_wdata_o,
    output logic                              busy_o,
    output logic                              done_o,
    output logic                              error_flag_o,
    output logic                              zero_result_flag_o,
    output logic                              sign_flag_o
);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------

    logic [1:0] rst_sync;
    logic       rst_n;

    // Reset asserts at once and releases two edges later.
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // ------------------------------------------------------------------
    // Sequencer and datapath
    // ------------------------------------------------------------------

    wsg_pkg::wsg_state_t           state;
    wsg_pkg::wsg_state_t           next_state;
    logic [wsg_pkg::OP_W-1:0]      op;
    logic [wsg_pkg::OP_W-1:0]      next_op;
    logic [wsg_pkg::ADDR_W-1:0]    addr_a;
    logic [wsg_pkg::ADDR_W-1:0]    next_addr_a;
    logic [wsg_pkg::ADDR_W-1:0]    addr_b;
    logic [wsg_pkg::ADDR_W-1:0]    next_addr_b;
    logic [wsg_pkg::ADDR_W-1:0]    indexed;
    logic [wsg_pkg::ADDR_W-1:0]    next_indexed;
    logic [wsg_pkg::DATA_W-1:0]    hold_a;
    logic [wsg_pkg::DATA_W-1:0]    next_hold_a;
    logic [wsg_pkg::ADDR_W-1:0]    next_mem_addr;
    logic                          next_mem_rd;
    logic                          next_mem_wr;
    logic [wsg_pkg::DATA_W-1:0]    next_mem_wdata;
    logic                          next_busy;
    logic                          next_done;
    logic                          next_err;
    logic                          next_zero;
    logic                          next_sign;

    wsg_word_if flg_if ();

    // The word under evaluation is always the word just read.
    assign flg_if.word = mem_rdata_i;

    wsg_word_flags u_flags (
        .flg (flg_if.eval)
    );

    // Next-state logic; every output is a register loaded from here.
    always_comb begin
        next_state     = state;
        next_op        = op;
        next_addr_a    = addr_a;
        next_addr_b    = addr_b;
        next_indexed   = indexed;
        next_hold_a    = hold_a;
        next_mem_addr  = mem_addr_o;
        next_mem_rd    = 1'b0;
        next_mem_wr    = 1'b0;
        next_mem_wdata = mem_wdata_o;
        next_busy      = busy_o;
        next_done      = 1'b0;
        next_err       = error_flag_o;
        next_zero      = zero_result_flag_o;
        next_sign      = sign_flag_o;
        unique case (state)
            wsg_pkg::ST_IDLE: begin
                // Unknown codes are ignored: no access, no done.
                if (start_i && (op_code_i == wsg_pkg::OP_SWAP_WORDS ||
                                op_code_i == wsg_pkg::OP_SCATTER ||
                                op_code_i == wsg_pkg::OP_GATHER)) begin
                    next_op      = op_code_i;
                    next_addr_a  = first_swap_word_i;
                    next_addr_b  = second_swap_word_i;
                    // unsigned displacement
                    // Plain 16-bit sum; every displacement is legal, wrap is the program's care.
                    next_indexed = wsg_pkg::ADDR_W'(base_word_address_i + index_displacement_i);
                    next_mem_rd  = 1'b1;
                    next_busy    = 1'b1;
                    // gather reads the indexed word first
                    next_mem_addr = (op_code_i == wsg_pkg::OP_GATHER) ? next_indexed
                                                                      : first_swap_word_i;
                    next_state   = wsg_pkg::ST_RDA;
                end
            end
            wsg_pkg::ST_RDA: begin
                if (op == wsg_pkg::OP_SWAP_WORDS) begin
                    next_mem_rd   = 1'b1;
                    next_mem_addr = addr_b;
                    next_state    = wsg_pkg::ST_RDB;
                end else begin
                    next_state    = wsg_pkg::ST_WAIT;
                end
            end
            wsg_pkg::ST_RDB: begin
                // First word arrives here and is held for the second write.
                next_hold_a = mem_rdata_i;
                next_state  = wsg_pkg::ST_WAITB;
            end
            wsg_pkg::ST_WAITB: begin
                next_mem_wr    = 1'b1;
                next_mem_addr  = addr_a;
                next_mem_wdata = mem_rdata_i;
                next_state     = wsg_pkg::ST_WRA;
            end
            wsg_pkg::ST_WRA: begin
                next_mem_wr    = 1'b1;
                next_mem_addr  = addr_b;
                next_mem_wdata = hold_a;
                next_state     = wsg_pkg::ST_WRB;
            end
            wsg_pkg::ST_WRB: begin
                next_busy  = 1'b0;
                next_done  = 1'b1;
                next_state = wsg_pkg::ST_IDLE;
            end
            wsg_pkg::ST_WAIT: begin
                // scatter writes to the indexed word
                next_mem_wr    = 1'b1;
                next_mem_addr  = (op == wsg_pkg::OP_SCATTER) ? indexed : addr_b;
                next_mem_wdata = mem_rdata_i;
                next_zero      = flg_if.zero;
                next_sign      = flg_if.sign;
                next_err       = 1'b0;
                next_state     = wsg_pkg::ST_WR;
            end
            wsg_pkg::ST_WR: begin
                next_busy  = 1'b0;
                next_done  = 1'b1;
                next_state = wsg_pkg::ST_IDLE;
            end
        endcase
    end

    // State registers; clock enable low freezes everything.
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            state              <= wsg_pkg::ST_IDLE;
            op                 <= wsg_pkg::OP_RST;
            addr_a             <= wsg_pkg::ADDR_RST;
            addr_b             <= wsg_pkg::ADDR_RST;
            indexed            <= wsg_pkg::ADDR_RST;
            hold_a             <= wsg_pkg::WORD_ZERO;
            mem_addr_o         <= wsg_pkg::ADDR_RST;
            mem_rd_o           <= 1'b0;
            mem_wr_o           <= 1'b0;
            mem_wdata_o        <= wsg_pkg::WORD_ZERO;
            busy_o             <= 1'b0;
            done_o             <= 1'b0;
            error_flag_o       <= wsg_pkg::FLAG_RST;
            zero_result_flag_o <= wsg_pkg::FLAG_RST;
            sign_flag_o        <= wsg_pkg::FLAG_RST;
        end else if (ce_i) begin
            state              <= next_state;
            op                 <= next_op;
            addr_a             <= next_addr_a;
            addr_b             <= next_addr_b;
            indexed            <= next_indexed;
            hold_a             <= next_hold_a;
            mem_addr_o         <= next_mem_addr;
            mem_rd_o           <= next_mem_rd;
            mem_wr_o           <= next_mem_wr;
            mem_wdata_o        <= next_mem_wdata;
            busy_o             <= next_busy;
            done_o             <= next_done;
            error_flag_o       <= next_err;
            zero_result_flag_o <= next_zero;
            sign_flag_o        <= next_sign;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------

    default clocking chk_clk @(posedge mclk_i iff ce_i);
    endclocking
    default disable iff (!rst_n);

    swap_first_word_a: assert property (
        state == wsg_pkg::ST_WRA |-> mem_wr_o && mem_addr_o == $past(mem_addr_o, 3)
            && mem_wdata_o == $past(mem_rdata_i, 1))
        else $error("swap first word write wrong");

    swap_second_word_a: assert property (
        state == wsg_pkg::ST_WRB |-> mem_wr_o && mem_addr_o == $past(mem_addr_o, 3)
            && mem_wdata_o == $past(mem_rdata_i, 3))
        else $error("swap second word write wrong");

    scatter_dest_a: assert property (
        state == wsg_pkg::ST_WAIT && op == wsg_pkg::OP_SCATTER |=> mem_wr_o
            && mem_addr_o == indexed && mem_wdata_o == $past(mem_rdata_i))
        else $error("scatter write address or data wrong");

    gather_source_a: assert property (
        $rose(busy_o) && op == wsg_pkg::OP_GATHER |-> mem_rd_o && mem_addr_o == indexed
            ##2 mem_wr_o && mem_addr_o == addr_b && mem_wdata_o == $past(mem_rdata_i))
        else $error("gather read or write wrong");

    offset_unsigned_a: assert property (
        state == wsg_pkg::ST_RDA |-> wsg_pkg::ADDR_W'(indexed - $past(base_word_address_i))
            == $past(index_displacement_i))
        else $error("indexed address is not base plus displacement");

    zero_flag_a: assert property (
        state == wsg_pkg::ST_WR |-> zero_result_flag_o == (mem_wdata_o == wsg_pkg::WORD_ZERO))
        else $error("zero flag disagrees with moved word");

    sign_flag_a: assert property (
        state == wsg_pkg::ST_WR ##1 done_o |->
            sign_flag_o == $past(mem_wdata_o[wsg_pkg::SIGN_BIT_POS]))
        else $error("sign flag disagrees with moved word");

    swap_flags_kept_a: assert property (
        done_o && op == wsg_pkg::OP_SWAP_WORDS |->
            {error_flag_o, zero_result_flag_o, sign_flag_o} ==
            $past({error_flag_o, zero_result_flag_o, sign_flag_o}, 5))
        else $error("swap changed a condition flag");

    error_cleared_a: assert property (
        state == wsg_pkg::ST_WAIT |=> !error_flag_o [*2])
        else $error("indexed operation left error flag set");

    swap_done_c: cover property (done_o && op == wsg_pkg::OP_SWAP_WORDS);
    scatter_done_c: cover property (done_o && op == wsg_pkg::OP_SCATTER);
    gather_done_c: cover property (done_o && op == wsg_pkg::OP_GATHER && zero_result_flag_o);
    max_offset_c: cover property (state == wsg_pkg::ST_RDA && op == wsg_pkg::OP_GATHER
        && $past(index_displacement_i) == 16'hFFFF);

endmodule

// file: testbench/wsg_top_tb_top.sv
/*
 * Self-checking testbench for the swap, scatter and gather word datapath.
 * Assumes the design package and top module are compiled first; the bench itself
 * models the word data area with a one-cycle registered read port.
 */
`timescale 1ns/100ps

module wsg_top_tb_top;

    // ------------------------------------------------------------------
    // Signals and data area model
    // ------------------------------------------------------------------
    logic        mclk_i               = 1'b0;
    logic        nrst_i               = 1'b0;
    logic        ce_i                 = 1'b1;
    logic        start_i              = 1'b0;
    logic [11:0] op_code_i            = 12'h000;
    logic [15:0] first_swap_word_i    = 16'h0000;
    logic [15:0] second_swap_word_i   = 16'h0000;
    logic [15:0] base_word_address_i  = 16'h0000;
    logic [15:0] index_displacement_i = 16'h0000;
    logic [15:0] mem_rdata_i          = 16'h0000;
    logic [15:0] mem_addr_o;
    logic        mem_rd_o;
    logic        mem_wr_o;
    logic [15:0] mem_wdata_o;
    logic        busy_o;
    logic        done_o;
    logic        error_flag_o;
    logic        zero_result_flag_o;
    logic        sign_flag_o;
    logic [15:0] mem [0:65535];
    int          fails        = 0;
    int          total_checks = 0;

    // The clock toggles every 12.5 ns, half of its 25 ns period.
    always #12.5 mclk_i = ~mclk_i;

    // Read data is registered; between reads it flips so stale data never matches.
    always @(posedge mclk_i) begin
        if (ce_i) begin
            if (mem_wr_o) mem[mem_addr_o] <= mem_wdata_o;
            mem_rdata_i <= mem_rd_o ? mem[mem_addr_o] : ~mem_rdata_i;
        end
    end

    wsg_top dut_u (
        .mclk_i               (mclk_i),
        .nrst_i               (nrst_i),
        .ce_i                 (ce_i),
        .start_i              (start_i),
        .op_code_i            (op_code_i),
        .first_swap_word_i    (first_swap_word_i),
        .second_swap_word_i   (second_swap_word_i),
        .base_word_address_i  (base_word_address_i),
        .index_displacement_i (index_displacement_i),
        .mem_rdata_i          (mem_rdata_i),
        .mem_addr_o           (mem_addr_o),
        .mem_rd_o             (mem_rd_o),
        .mem_wr_o             (mem_wr_o),
        .mem_wdata_o          (mem_wdata_o),
        .busy_o               (busy_o),
        .done_o               (done_o),
        .error_flag_o         (error_flag_o),
        .zero_result_flag_o   (zero_result_flag_o),
        .sign_flag_o          (sign_flag_o)
    );

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    // Compares one value and counts the result.
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Issues one request and counts clock edges, enabled or not, until done, bounded at 20.
    task automatic run_op(input logic [11:0] code, input logic [15:0] a, input logic [15:0] b,
                          input logic [15:0] base, input logic [15:0] disp,
                          output int n, output logic busy1);
        @(posedge mclk_i);
        #1;
        op_code_i            = code;
        first_swap_word_i    = a;
        second_swap_word_i   = b;
        base_word_address_i  = base;
        index_displacement_i = disp;
        start_i              = 1'b1;
        @(posedge mclk_i);
        #1;
        start_i = 1'b0;
        busy1   = busy_o;
        n       = 1;
        while (done_o !== 1'b1 && n < 20) begin
            @(posedge mclk_i);
            #1;
            n++;
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("checks=%0d mismatches=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // Moves a word out to base plus displacement (scatter) or in from it (gather), for three cases.
    task automatic test_indexed(input logic gather);
        logic [15:0] vals [3] = '{16'h0000, 16'h7FFF, 16'h8001};
        // area kept
        // Every base and computed word stay inside the single 64K-word area, no wrap.
        logic [15:0] bases[3] = '{16'h0100, 16'h0300, 16'h0000};
        logic [15:0] disps[3] = '{16'h0000, 16'h000A, 16'hFFFF};
        logic [15:0] tgt;
        int          n;
        logic        b1;
        for (int i = 0; i < 3; i++) begin
            tgt = bases[i] + disps[i];
            mem[gather ? tgt : 16'h0050] = vals[i];
            mem[gather ? 16'h0060 : tgt] = ~vals[i];
            run_op(gather ? wsg_pkg::OP_GATHER : wsg_pkg::OP_SCATTER, 16'h0050, 16'h0060,
                   bases[i], disps[i], n, b1);
            chk(16'(b1), 16'h0001);
            chk(16'(n), 16'h0004);
            chk(16'(busy_o), 16'h0000);
            // Word lands at the computed or destination place.
            chk(mem[gather ? 16'h0060 : tgt], vals[i]);
            chk(16'(zero_result_flag_o), 16'(vals[i] == 16'h0000));
            chk(16'(sign_flag_o), 16'(vals[i][15]));
            chk(16'(error_flag_o), 16'h0000);
        end
        $display("test indexed gather=%0d finished", gather);
    endtask

    // Exchanges two words with the flags left set by the last indexed operation.
    task automatic test_swap();
        logic [2:0] flags;
        int         n;
        logic       b1;
        mem[16'h0400] = 16'h1234;
        mem[16'h0401] = 16'hABCD;
        flags = {error_flag_o, zero_result_flag_o, sign_flag_o};
        // two words only
        // Only a pair is exchanged; longer exchanges are left to block copy through a buffer.
        run_op(wsg_pkg::OP_SWAP_WORDS, 16'h0400, 16'h0401, 16'h0000, 16'h0000, n, b1);
        chk(16'(n), 16'h0006);
        chk(mem[16'h0400], 16'hABCD);
        chk(mem[16'h0401], 16'h1234);
        chk(16'({error_flag_o, zero_result_flag_o, sign_flag_o}), 16'(flags));
        $display("test swap finished");
    endtask

    // An unknown code is dropped: no busy, no done, no write.
    task automatic test_bad_code();
        int   n;
        logic b1;
        mem[16'h0500] = 16'h5555;
        run_op(12'h074, 16'h0500, 16'h0501, 16'h0500, 16'h0000, n, b1);
        chk(16'(b1), 16'h0000);
        chk(16'(n), 16'h0014);
        chk(mem[16'h0500], 16'h5555);
        $display("test bad code finished");
    endtask

    // Drops the clock enable for three edges in mid-scatter; the operation must freeze
    // there and finish exactly three edges late with the right word and sign and error flags.
    task automatic test_ce_hold();
        int   n;
        logic b1;
        mem[16'h0070] = 16'h4321;
        fork
            run_op(wsg_pkg::OP_SCATTER, 16'h0070, 16'h0000, 16'h0700, 16'h0001, n, b1);
            begin
                repeat (3) @(posedge mclk_i);
                #1;
                ce_i = 1'b0;
                repeat (3) @(posedge mclk_i);
                #1;
                ce_i = 1'b1;
            end
        join
        chk(16'(b1), 16'h0001);
        chk(16'(n), 16'h0007);
        chk(mem[16'h0701], 16'h4321);
        chk(16'(sign_flag_o), 16'h0000);
        chk(16'(error_flag_o), 16'h0000);
        $display("test clock enable hold finished");
    endtask

    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    // Holds reset for 10 cycles, checks idle outputs, then runs the scenarios.
    initial begin
        repeat (10) @(posedge mclk_i);
        #1;
        chk(16'({busy_o, done_o, mem_rd_o, mem_wr_o, error_flag_o, zero_result_flag_o,
                 sign_flag_o}), 16'h0000);
        nrst_i = 1'b1;
        repeat (3) @(posedge mclk_i);
        $display("test reset finished");
        test_indexed(1'b0);
        test_indexed(1'b1);
        test_swap();
        test_bad_code();
        test_ce_hold();
        results();
    end

    // Cuts a hang short well after the expected run of about 80 cycles.
    initial begin
        #(25 * 4000);
        fails++;
        results();
    end

endmodule
